/* File: rtl/eft_frame_timing.sv */
`default_nettype none
module eft_frame_timing #(
    parameter int SENSOR_COLS = 5120,
    parameter int SENSOR_ROWS = 5120,
    parameter int FIFO_DEPTH = 8
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic ext_expo,
    input wire logic link_clk,
    input wire logic ext_sel,
    input wire logic [eft_pkg::US_W-1:0] exp_time_us,
    input wire logic frame_time_en,
    input wire logic [eft_pkg::US_W-1:0] frame_time_us,
    input wire logic row_blank_suppress,
    input wire logic pix_avg_en,
    input wire eft_pkg::eft_tap_t tap_sel,
    input wire logic depth10,
    input wire logic [7:0] pix_clk_div,
    input wire logic [eft_pkg::COORD_W-1:0] win_h_size,
    input wire logic [eft_pkg::COORD_W-1:0] win_v_size,
    input wire logic [eft_pkg::COORD_W-1:0] win_h_off,
    input wire logic [eft_pkg::COORD_W-1:0] win_v_off,
    input wire logic [eft_pkg::TAP_MAX*eft_pkg::PIX_W-1:0] array_data,
    output logic pix_reset,
    output logic charge_xfer,
    output logic expo_active,
    output logic frame_busy,
    output logic array_rd,
    output logic [eft_pkg::COORD_W-1:0] array_row,
    output logic [eft_pkg::COORD_W-1:0] array_col,
    output logic [eft_pkg::TAP_MAX*eft_pkg::PIX_W-1:0] link_taps,
    output logic link_dval,
    output logic link_lend,
    output logic link_fend,
    output eft_pkg::eft_tap_t link_tap_sel,
    output logic link_depth10
);
    localparam int CW = eft_pkg::COORD_W;
    localparam int UW = eft_pkg::US_W;
    localparam int DW = eft_pkg::TAP_MAX * eft_pkg::PIX_W;
    localparam logic [CW-1:0] MAX_H = CW'(SENSOR_COLS);
    localparam logic [CW-1:0] MAX_V = CW'(SENSOR_ROWS);

    typedef struct packed {
        eft_pkg::eft_rd_t rd;
        eft_pkg::eft_ex_t ex;
        logic [4:0] tick;
        logic [UW-1:0] frame_us;
        logic [UW-1:0] read_us;
        logic [UW-1:0] exp_us;
        logic [UW-1:0] exp_len;
        logic [UW-1:0] exp_set;
        logic [UW-1:0] ft_us;
        logic ft_en;
        logic ext_sel;
        logic ext_q;
        logic lclk_q;
        eft_pkg::eft_tap_t tap_sel;
        logic depth10;
        logic avg;
        logic sup_eff;
        logic [7:0] div;
        logic [7:0] beat;
        logic [4:0] blank;
        logic [CW-1:0] h_size;
        logic [CW-1:0] v_size;
        logic [CW-1:0] h_off;
        logic [CW-1:0] v_off;
        logic [CW-1:0] row;
        logic [CW-1:0] col;
        logic pix_reset;
        logic charge_xfer;
        logic expo_active;
        logic frame_busy;
        logic array_rd;
        logic pend_lend;
        logic pend_fend;
        logic [CW-1:0] array_row;
        logic [CW-1:0] array_col;
        logic [DW-1:0] link_taps;
        logic link_dval;
        logic link_lend;
        logic link_fend;
        eft_pkg::eft_tap_t link_tap_sel;
        logic link_depth10;
    } eft_state_t;

    eft_state_t cur;
    eft_state_t next_s;
    logic rst_n;
    logic [1:0] pins_s;
    logic ext_s;
    logic lclk_s;
    logic f_in_ready;
    logic f_out_valid;
    logic [DW+4:0] f_out_data;
    logic [DW-1:0] fmt;
    logic [3:0] ntaps;
    logic us_tick;
    logic start_due;
    logic last_col;
    logic last_row;
    logic [UW-1:0] period;
    logic [UW-1:0] exp_clip;
    logic [UW-1:0] exp_want;
    logic [CW-1:0] w_h;
    logic [CW-1:0] w_v;
    logic [CW-1:0] w_ho;
    logic [CW-1:0] w_vo;

    eft_sync #(.W(1)) u_rst_sync (
        .clk(core_clk),
        .arst_n(rst_b),
        .en(1'b1),
        .d(1'b1),
        .q(rst_n)
    );

    eft_sync #(.W(2)) u_pin_sync (
        .clk(core_clk),
        .arst_n(rst_n),
        .en(ce),
        .d({ext_expo, link_clk}),
        .q(pins_s)
    );
    assign ext_s = pins_s[1];
    assign lclk_s = pins_s[0];

    // Readout stalls on a full FIFO instead of dropping pixels
    // Format travels with each word, so a frame still draining keeps its own
    eft_fifo #(.W(DW + 5), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(core_clk),
        .rst_n(rst_n),
        .ce(ce),
        .in_valid(cur.array_rd),
        .in_ready(f_in_ready),
        .in_data({cur.tap_sel, cur.depth10, cur.pend_fend, cur.pend_lend, fmt}),
        .out_valid(f_out_valid),
        .out_ready(lclk_s && !cur.lclk_q),
        .out_data(f_out_data)
    );

    assign ntaps = eft_pkg::eft_taps(cur.tap_sel); // R12

    for (genvar t = 0; t < eft_pkg::TAP_MAX; t++) begin : g_tap
        // Eight-bit mode keeps the upper bits of each pixel
        assign fmt[t*eft_pkg::PIX_W +: eft_pkg::PIX_W] = (4'(t) >= ntaps) ? '0 :
            cur.depth10 ? array_data[t*eft_pkg::PIX_W +: eft_pkg::PIX_W] :
            {2'h0, array_data[t*eft_pkg::PIX_W+2 +: 8]}; // R13 R12
    end

    always_comb begin
        next_s = cur;
        next_s.pix_reset = 1'b0;
        next_s.charge_xfer = 1'b0;
        next_s.array_rd = 1'b0;
        next_s.ext_q = ext_s;
        next_s.lclk_q = lclk_s;
        us_tick = cur.tick == eft_pkg::TICK_LAST;
        next_s.tick = us_tick ? 5'h00 : cur.tick + 5'h01;
        if (us_tick && cur.frame_us != eft_pkg::FRAME_MAX_US) begin
            next_s.frame_us = cur.frame_us + 20'h00001; // R8
        end
        period = (cur.ft_en && cur.ft_us > cur.read_us) ? cur.ft_us : cur.read_us; // R5 R7 R17
        exp_clip = (cur.exp_set > period) ? period : cur.exp_set; // R2 R9
        exp_want = (exp_clip < eft_pkg::EXP_MIN_US) ? eft_pkg::EXP_MIN_US : exp_clip; // R2
        start_due = ({1'b0, cur.frame_us} + {1'b0, exp_want}) >= {1'b0, period};
        last_col = ({1'b0, cur.col} + {10'h000, ntaps}) >= ({1'b0, cur.h_off} + {1'b0, cur.h_size});
        last_row = cur.row == cur.v_off + cur.v_size - 13'h0001;
        w_h = win_h_size & eft_pkg::WIN_H_MASK; // R16
        w_h = (w_h < eft_pkg::WIN_MIN_H) ? eft_pkg::WIN_MIN_H : (w_h > MAX_H) ? MAX_H : w_h; // R16
        w_v = (win_v_size < eft_pkg::WIN_MIN_V) ? eft_pkg::WIN_MIN_V : (win_v_size > MAX_V) ? MAX_V : win_v_size;
        w_ho = (win_h_off > MAX_H - w_h) ? MAX_H - w_h : win_h_off; // R15
        w_vo = (win_v_off > MAX_V - w_v) ? MAX_V - w_v : win_v_off; // R15

        // Link side: one FIFO word per sampled rising link clock edge
        if (lclk_s && !cur.lclk_q) begin
            next_s.link_dval = f_out_valid; // R14
            if (f_out_valid) begin
                next_s.link_fend = f_out_data[DW+1];
                next_s.link_lend = f_out_data[DW];
                next_s.link_taps = f_out_data[DW-1:0];
                next_s.link_tap_sel = eft_pkg::eft_tap_t'(f_out_data[DW+4:DW+3]); // R12 R18
                next_s.link_depth10 = f_out_data[DW+2]; // R13 R18
            end
        end

        // Exposure runs on its own, overlapping the previous frame's readout
        case (cur.ex)
            eft_pkg::EFT_EX_WAIT: begin
                if (cur.ext_sel ? (ext_s && !cur.ext_q) : (us_tick && start_due)) begin // R3 R4
                    next_s.ex = eft_pkg::EFT_EX_RUN;
                    next_s.pix_reset = 1'b1; // R1
                    next_s.expo_active = 1'b1;
                    next_s.exp_us = '0;
                    next_s.exp_len = exp_want;
                end
            end
            eft_pkg::EFT_EX_RUN: begin
                if (us_tick && cur.exp_us != eft_pkg::FRAME_MAX_US) begin
                    next_s.exp_us = cur.exp_us + 20'h00001;
                end
                // A pulse shorter than the floor is stretched to the floor
                if (cur.ext_sel ? (!ext_s && cur.exp_us >= eft_pkg::EXP_MIN_US) // R4
                                : (cur.exp_us >= cur.exp_len)) begin // R2
                    next_s.ex = eft_pkg::EFT_EX_DONE;
                end
            end
            eft_pkg::EFT_EX_DONE: begin
            end
            default: begin
                next_s.ex = eft_pkg::EFT_EX_WAIT;
            end
        endcase

        case (cur.rd)
            eft_pkg::EFT_RD_IDLE: begin
            end
            eft_pkg::EFT_RD_LINE: begin
                if (cur.beat != 8'h00) begin
                    next_s.beat = cur.beat - 8'h01; // R6
                end else if (f_in_ready && !cur.array_rd) begin
                    next_s.array_rd = 1'b1;
                    next_s.array_row = cur.row;
                    next_s.array_col = cur.col;
                    next_s.pend_lend = last_col;
                    next_s.pend_fend = last_col && last_row;
                    next_s.beat = cur.div; // R6
                    if (!last_col) begin
                        next_s.col = cur.col + {9'h000, ntaps};
                    end else begin
                        next_s.col = cur.h_off;
                        if (!last_row) begin
                            next_s.row = cur.row + 13'h0001;
                        end
                        if (!cur.sup_eff) begin
                            next_s.rd = eft_pkg::EFT_RD_RBLANK; // R10
                            next_s.blank = eft_pkg::BLANK_LAST;
                        end else if (last_row) begin
                            next_s.rd = eft_pkg::EFT_RD_IDLE;
                            next_s.frame_busy = 1'b0;
                            next_s.read_us = cur.frame_us; // R5
                        end
                    end
                end
            end
            eft_pkg::EFT_RD_RBLANK: begin
                if (cur.blank != 5'h00) begin
                    next_s.blank = cur.blank - 5'h01; // R10
                end else if (cur.pend_fend) begin
                    next_s.rd = eft_pkg::EFT_RD_IDLE;
                    next_s.frame_busy = 1'b0;
                    next_s.read_us = cur.frame_us; // R5
                end else begin
                    next_s.rd = eft_pkg::EFT_RD_LINE;
                end
            end
            default: begin
                next_s.rd = eft_pkg::EFT_RD_IDLE;
            end
        endcase

        // Frame boundary: transfer after exposure, once readout and any blanking end
        if (cur.ex == eft_pkg::EFT_EX_DONE && cur.rd == eft_pkg::EFT_RD_IDLE
                && (!cur.ft_en || cur.frame_us >= cur.ft_us)) begin // R7 R17
            next_s.charge_xfer = 1'b1; // R1
            next_s.expo_active = 1'b0;
            next_s.ex = eft_pkg::EFT_EX_WAIT;
            next_s.frame_us = '0;
            next_s.tick = 5'h00;
            next_s.ext_sel = ext_sel; // R18
            next_s.exp_set = exp_time_us;
            next_s.ft_en = frame_time_en;
            next_s.ft_us = (frame_time_us > eft_pkg::FRAME_MAX_US) ? eft_pkg::FRAME_MAX_US : frame_time_us; // R8
            next_s.tap_sel = tap_sel;
            next_s.depth10 = depth10;
            next_s.avg = pix_avg_en;
            next_s.sup_eff = row_blank_suppress && !pix_avg_en && tap_sel != eft_pkg::EFT_TAP2; // R11
            next_s.div = pix_clk_div;
            next_s.h_size = w_h;
            next_s.v_size = w_v;
            next_s.h_off = w_ho;
            next_s.v_off = w_vo;
            next_s.row = w_vo;
            next_s.col = w_ho;
            next_s.beat = 8'h00;
            next_s.rd = eft_pkg::EFT_RD_LINE; // R1
            next_s.frame_busy = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '0;
        end else if (ce) begin
            cur <= next_s;
        end
    end

    assign pix_reset = cur.pix_reset;
    assign charge_xfer = cur.charge_xfer;
    assign expo_active = cur.expo_active;
    assign frame_busy = cur.frame_busy;
    assign array_rd = cur.array_rd;
    assign array_row = cur.array_row;
    assign array_col = cur.array_col;
    assign link_taps = cur.link_taps;
    assign link_dval = cur.link_dval;
    assign link_lend = cur.link_lend;
    assign link_fend = cur.link_fend;
    assign link_tap_sel = cur.link_tap_sel;
    assign link_depth10 = cur.link_depth10;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n || !ce);

    sequence s_line_to_blank;
        cur.rd == eft_pkg::EFT_RD_LINE ##1 cur.rd == eft_pkg::EFT_RD_RBLANK;
    endsequence
    sequence s_xfer_then_read;
        cur.charge_xfer ##1 cur.rd == eft_pkg::EFT_RD_LINE;
    endsequence

    xfer_start_read_a: assert property (cur.charge_xfer |-> cur.rd == eft_pkg::EFT_RD_LINE && !cur.expo_active // R1
        && $past(cur.rd) == eft_pkg::EFT_RD_IDLE && $past(cur.ex) == eft_pkg::EFT_EX_DONE)
        else $error("transfer without finished exposure and idle readout");
    reset_opens_expo_a: assert property (cur.pix_reset |-> cur.expo_active && !$past(cur.expo_active)) // R1
        else $error("pixel reset does not open exposure");
    expo_floor_a: assert property (cur.ex == eft_pkg::EFT_EX_DONE && $past(cur.ex) == eft_pkg::EFT_EX_RUN // R2
        |-> $past(cur.exp_us) >= 20'h00028) else $error("exposure shorter than 40 us");
    expo_overlap_a: assert property (cur.rd == eft_pkg::EFT_RD_LINE && cur.ex == eft_pkg::EFT_EX_WAIT // R3
        && !cur.ext_sel && us_tick && start_due |=> cur.pix_reset && cur.frame_busy)
        else $error("exposure not started during readout");
    ext_pulse_end_a: assert property (cur.ext_sel && cur.ex == eft_pkg::EFT_EX_RUN && !ext_s // R4
        && cur.exp_us >= 20'h00028 |=> cur.ex == eft_pkg::EFT_EX_DONE) else $error("pulse end missed");
    frame_time_a: assert property (cur.charge_xfer && $past(cur.ft_en) // R7
        |-> $past(cur.frame_us) >= $past(cur.ft_us)) else $error("frame shorter than frame time");
    row_blank_a: assert property (s_line_to_blank |-> ##19 cur.rd == eft_pkg::EFT_RD_RBLANK // R10
        ##1 cur.rd != eft_pkg::EFT_RD_RBLANK) else $error("row blank not 1 us");
    suppress_guard_a: assert property (cur.sup_eff |-> !cur.avg && cur.tap_sel != eft_pkg::EFT_TAP2) // R11
        else $error("row blank suppressed in unsupported mode");
    window_min_a: assert property (s_xfer_then_read |-> cur.h_size >= 13'h0140 // R16
        && cur.h_size[2:0] == 3'h0 && cur.v_size >= 13'h0002) else $error("window below minimum");
    depth_eight_a: assert property (cur.link_dval && !cur.link_depth10 |-> cur.link_taps[9:8] == 2'h0) // R13
        else $error("eight bit pixel has upper bits set");
    cfg_frame_edge_a: assert property ($changed(cur.tap_sel) || $changed(cur.h_size) // R18
        |-> cur.charge_xfer) else $error("settings changed inside a frame");
endmodule : eft_frame_timing
`default_nettype wire

/* File: rtl/eft_pkg.sv */
// Function
// R1: Global reset, common exposure, transfer before readout
// R2: Internal exposure between 40 us and frame period
// R3: Next exposure overlaps current frame readout
// R4: External pulse sets exposure, at least 40 us
// R5: Plain frame period equals readout time
// R6: Programmable pixel readout rate
// R7: Frame time adds vertical blanking after readout
// R8: Frame time in 1 us steps, about 1 s
// R9: Frame time permits exposure beyond readout time
// R10: Row blank 1 us unless suppressed
// R11: No suppression with averaging or two taps
// R12: Two, four, eight or ten taps
// R13: Eight or ten bit pixels
// R14: Link output paced by 85 MHz link clock; here its rises are sampled on the 50 ns (20 MHz) core clock
// R15: One readout window: sizes and offsets
// R16: Window at least 320 x 2, width step 8
// R17: Too short frame time falls back to readout
// R18: Settings change only at frame boundary
`default_nettype none
package eft_pkg;
    localparam int CLK_NS = 50;
    localparam int US_NS = 1000;
    localparam int FRAME_STEP_US = 1;
    localparam int TICK_CYC = (FRAME_STEP_US * US_NS + CLK_NS - 1) / CLK_NS;
    localparam int EXP_MIN_US_FIG = 40;
    localparam int ROW_BLANK_US = 1;
    localparam int ROW_BLANK_CYC = (ROW_BLANK_US * US_NS + CLK_NS - 1) / CLK_NS;
    localparam int FRAME_MAX_US_FIG = 1000000;
    localparam int LINK_CLK_MHZ = 85;
    localparam int US_W = 20;
    localparam int COORD_W = 13;
    localparam int TAP_MAX = 10;
    localparam int PIX_W = 10;
    localparam int WIN_MIN_H_FIG = 320;
    localparam int WIN_MIN_V_FIG = 2;
    localparam logic [4:0] TICK_LAST = 5'(TICK_CYC - 1);
    localparam logic [4:0] BLANK_LAST = 5'(ROW_BLANK_CYC - 1);
    localparam logic [US_W-1:0] EXP_MIN_US = US_W'(EXP_MIN_US_FIG);
    localparam logic [US_W-1:0] FRAME_MAX_US = US_W'(FRAME_MAX_US_FIG);
    localparam logic [COORD_W-1:0] WIN_MIN_H = COORD_W'(WIN_MIN_H_FIG);
    localparam logic [COORD_W-1:0] WIN_MIN_V = COORD_W'(WIN_MIN_V_FIG);
    localparam logic [COORD_W-1:0] WIN_H_MASK = 13'h1ff8;

    typedef enum logic [1:0] {
        EFT_TAP2 = 2'b00,
        EFT_TAP4 = 2'b01,
        EFT_TAP8 = 2'b10,
        EFT_TAP10 = 2'b11
    } eft_tap_t;

    typedef enum logic [1:0] {
        EFT_RD_IDLE = 2'b00,
        EFT_RD_LINE = 2'b01,
        EFT_RD_RBLANK = 2'b10
    } eft_rd_t;

    typedef enum logic [1:0] {
        EFT_EX_WAIT = 2'b00,
        EFT_EX_RUN = 2'b01,
        EFT_EX_DONE = 2'b10
    } eft_ex_t;

    function automatic logic [3:0] eft_taps(input eft_tap_t sel);
        case (sel)
            EFT_TAP2: eft_taps = 4'h2;
            EFT_TAP4: eft_taps = 4'h4;
            EFT_TAP8: eft_taps = 4'h8;
            default: eft_taps = 4'ha;
        endcase
    endfunction : eft_taps
endpackage : eft_pkg
`default_nettype wire

/* File: rtl/eft_sync.sv */
`default_nettype none
module eft_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic en,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] out;
    } eft_sync_t;

    eft_sync_t cur;
    eft_sync_t next_s;

    always_comb begin
        next_s.meta = d;
        next_s.out = cur.meta;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cur <= '0;
        end else if (en) begin
            cur <= next_s;
        end
    end

    assign q = cur.out;
endmodule : eft_sync
`default_nettype wire

/* File: rtl/eft_fifo.sv */
`default_nettype none
module eft_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } eft_fifo_t;

    eft_fifo_t cur;
    eft_fifo_t next_s;
    logic push;
    logic pop;

    assign in_ready = cur.cnt != (AW + 1)'(DEPTH);
    assign out_valid = cur.cnt != '0;
    assign out_data = cur.mem[cur.rp];

    always_comb begin
        next_s = cur;
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        if (push) begin
            next_s.mem[cur.wp] = in_data;
            next_s.wp = (cur.wp == AW'(DEPTH - 1)) ? '0 : cur.wp + 1'b1;
        end
        if (pop) begin
            next_s.rp = (cur.rp == AW'(DEPTH - 1)) ? '0 : cur.rp + 1'b1;
        end
        if (push && !pop) begin
            next_s.cnt = cur.cnt + 1'b1;
        end else if (pop && !push) begin
            next_s.cnt = cur.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '0;
        end else if (ce) begin
            cur <= next_s;
        end
    end
endmodule : eft_fifo
`default_nettype wire

/* File: bench/eft_grabber.sv */
`default_nettype none
module eft_grabber (
    input wire logic hold,
    input wire logic [99:0] link_taps,
    input wire logic link_dval,
    input wire logic link_lend,
    input wire logic link_fend,
    output logic link_clk
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [99:0] got [$];
    int lend_cnt = 0;
    int fend_cnt = 0;
    initial begin
        link_clk = 1'b0;
        // A held clock pops nothing, so the FIFO has to fill and refuse
        forever #200 if (hold !== 1'b1) link_clk = ~link_clk;
    end
    // Words settle a few core cycles after the rise, well before the fall
    always @(negedge link_clk) begin
        if (link_dval === 1'b1) begin
            got.push_back(link_taps);
            lend_cnt += int'(link_lend);
            fend_cnt += int'(link_fend);
        end
    end
endmodule : eft_grabber
`default_nettype wire

/* File: bench/eft_frame_timing_test.sv */
`default_nettype none
module eft_frame_timing_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0, rst_b = 1'b0, ext_expo = 1'b0, hold = 1'b0, link_clk;
    logic ext_sel = 1'b0, frame_time_en = 1'b0, row_blank_suppress = 1'b0, pix_avg_en = 1'b0, depth10 = 1'b1;
    logic [19:0] exp_time_us = 20'h00028, frame_time_us = 20'h00000;
    logic [7:0] pix_clk_div = 8'h00;
    logic [12:0] win_h_size = 13'h0140, win_v_size = 13'h0002, win_h_off = 13'h0000, win_v_off = 13'h0000;
    logic [12:0] array_row, array_col;
    logic [99:0] array_data, link_taps;
    eft_pkg::eft_tap_t tap_sel = eft_pkg::EFT_TAP10;
    eft_pkg::eft_tap_t link_tap_sel;
    logic pix_reset, charge_xfer, expo_active, frame_busy, array_rd, link_dval, link_lend, link_fend, link_depth10;
    int err_total = 0, cmp_count = 0, cyc = 0, t_rst = 0, t_xfer = 0, exp_len = 0, period = 0;
    int b_cnt = 0, busy_len = 0, rd_cnt = 0, n_xfer = 0, pk = 0, r1 = 0, e_cnt = 0;
    int s_tap = 3, s_d10 = 1, s_hs = 320, s_vs = 2, s_ho = 0, s_vo = 0, s_supp = 0, s_avg = 0;
    int s_div = 0, s_fte = 0, s_ft = 0, s_exp = 40, s_ext = 0, s_stall = 0;
    bit overlap = 1'b0;
    int tap_n [4] = '{2, 4, 8, 10};
    // Divider 20 puts beats 21 cycles apart; each row adds a 20 cycle blank unless suppressed
    int blk [4][4] = '{'{3, 0, 0, 1364}, '{3, 1, 0, 1324}, '{3, 1, 1, 1364}, '{0, 1, 0, 6740}};

    eft_frame_timing #(.SENSOR_COLS(640), .SENSOR_ROWS(8), .FIFO_DEPTH(8)) dut (
        .core_clk, .rst_b, .ce(1'b1), .ext_expo, .link_clk, .ext_sel, .exp_time_us, .frame_time_en,
        .frame_time_us, .row_blank_suppress, .pix_avg_en, .tap_sel, .depth10, .pix_clk_div, .win_h_size,
        .win_v_size, .win_h_off, .win_v_off, .array_data, .pix_reset, .charge_xfer, .expo_active, .frame_busy,
        .array_rd, .array_row, .array_col, .link_taps, .link_dval, .link_lend, .link_fend, .link_tap_sel,
        .link_depth10
    );
    eft_grabber g (.hold, .link_taps, .link_dval, .link_lend, .link_fend, .link_clk);

    function automatic logic [9:0] pix(input int r, input int c, input int k);
        return 10'(r * 37 + c * 5 + k);
    endfunction : pix
    // Pixel array answers in the same cycle as the address
    always_comb begin
        for (int t = 0; t < 10; t++) array_data[t*10+:10] = pix(int'(array_row), int'(array_col) + t, pk);
    end
    initial begin
        forever #25 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        rd_cnt <= rd_cnt + int'(array_rd === 1'b1);
        e_cnt <= expo_active === 1'b1 ? e_cnt + 1 : 0;
        b_cnt <= frame_busy === 1'b1 ? b_cnt + 1 : 0;
        if (frame_busy !== 1'b1 && b_cnt > 0) busy_len <= b_cnt;
        if (pix_reset === 1'b1) t_rst <= cyc;
        if (pix_reset === 1'b1 && frame_busy === 1'b1) overlap <= 1'b1;
        if (charge_xfer === 1'b1) begin
            check(e_cnt, cyc - t_rst);
            exp_len <= cyc - t_rst;
            period <= cyc - t_xfer;
            t_xfer <= cyc;
            n_xfer <= n_xfer + 1;
        end
    end

    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict
    task automatic check(input logic [99:0] seen, input logic [99:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // f=0 counts transfers, f=1 counts completed frames at the grabber
    task automatic wait_on(input int f, input int n);
        int k;
        k = (f != 0 ? g.fend_cnt : n_xfer) + n;
        for (int i = 0; i < 30000 && (f != 0 ? g.fend_cnt : n_xfer) < k; i++) @(posedge core_clk);
        if ((f != 0 ? g.fend_cnt : n_xfer) < k) begin
            err_total++;
            print_verdict();
        end
    endtask : wait_on
    // New settings land just after a transfer, so the frame in flight keeps the old ones
    task automatic run_frame();
        int tn, hs, vs, base, r0, idx;
        logic [9:0] p;
        logic [99:0] w;
        tn = tap_n[s_tap];
        hs = (s_hs & 'hff8) < 320 ? 320 : s_hs & 'hff8;
        vs = s_vs < 2 ? 2 : s_vs;
        wait_on(0, 1);
        repeat (100) @(posedge core_clk);
        tap_sel <= eft_pkg::eft_tap_t'(2'(s_tap));
        depth10 <= 1'(s_d10);
        win_h_size <= 13'(s_hs);
        win_v_size <= 13'(s_vs);
        win_h_off <= 13'(s_ho);
        win_v_off <= 13'(s_vo);
        row_blank_suppress <= 1'(s_supp);
        pix_avg_en <= 1'(s_avg);
        pix_clk_div <= 8'(s_div);
        frame_time_en <= 1'(s_fte);
        frame_time_us <= 20'(s_ft);
        exp_time_us <= 20'(s_exp);
        ext_sel <= 1'(s_ext);
        wait_on(1, 1);
        base = g.got.size();
        r0 = g.lend_cnt;
        if (s_stall != 0) begin
            repeat (60) @(posedge core_clk);
            hold <= 1'b1;
            r1 = rd_cnt;
            repeat (400) @(posedge core_clk);
            check(rd_cnt - r1 >= 8 && rd_cnt - r1 <= 9, 1);
            hold <= 1'b0;
        end
        wait_on(1, 1);
        check(g.got.size() - base, hs / tn * vs);
        check(g.lend_cnt - r0, vs);
        check(link_tap_sel, s_tap);
        check(link_depth10, s_d10);
        idx = base;
        for (int r = 0; r < vs; r++) begin
            for (int c = s_ho; c < s_ho + hs; c += tn) begin
                for (int t = 0; t < 10; t++) begin
                    p = pix(s_vo + r, c + t, pk);
                    w[t*10+:10] = t >= tn ? 10'h000 : s_d10 != 0 ? p : {2'b00, p[9:2]};
                end
                check(g.got[idx], w);
                idx++;
            end
        end
    endtask : run_frame

    initial begin
        void'($urandom(32'h915b));
        pk = int'($urandom_range(0, 1023));
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            s_tap = i;
            s_d10 = i % 2;
            run_frame();
            wait_on(0, 2);
            check(exp_len >= 780 && exp_len <= 840, 1);
            if (i < 2) check(period >= busy_len - 25 && period <= busy_len + 45, 1);
        end
        check(overlap, 1'b1);
        $display("end of tap and depth test");
        s_stall = 1;
        run_frame();
        s_stall = 0;
        $display("end of buffer stall test");
        s_hs = 327;
        s_vs = 1;
        s_ho = int'($urandom_range(0, 320));
        s_vo = int'($urandom_range(0, 6));
        run_frame();
        $display("end of window test");
        s_div = 20;
        for (int i = 0; i < 4; i++) begin
            s_tap = blk[i][0];
            s_supp = blk[i][1];
            s_avg = blk[i][2];
            run_frame();
            wait_on(0, 1);
            check(busy_len >= blk[i][3] - 15 && busy_len <= blk[i][3] + 15, 1);
        end
        s_div = 0;
        s_tap = 3;
        $display("end of row blank test");
        s_fte = 1;
        s_ft = 150;
        s_exp = 100;
        run_frame();
        wait_on(0, 2);
        check(period >= 2980 && period <= 3025, 1);
        check(exp_len >= 1980 && exp_len <= 2025, 1);
        check(busy_len < 1000, 1);
        s_ft = 5;
        s_exp = 40;
        run_frame();
        wait_on(0, 2);
        check(period >= 500 && period <= 1100, 1);
        $display("end of frame time test");
        s_fte = 0;
        s_ext = 1;
        run_frame();
        // Second pulse is shorter than the minimum and must still give the minimum exposure
        for (int i = 0; i < 2; i++) begin
            ext_expo <= 1'b1;
            repeat (i == 0 ? 1200 : 200) @(posedge core_clk);
            ext_expo <= 1'b0;
            wait_on(0, 1);
            check(exp_len >= (i == 0 ? 1180 : 780) && exp_len <= (i == 0 ? 1230 : 830), 1);
            repeat (100) @(posedge core_clk);
        end
        $display("end of external exposure test");
        print_verdict();
    end
endmodule : eft_frame_timing_test
`default_nettype wire
